// >>> src/bps_pkg.sv
`default_nettype none
package bps_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_M2B      = 8'h08;
  localparam logic [7:0] ADDR_B2M      = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // status field positions
  localparam int ST_TOTAL_FAIL = 0;
  localparam int ST_BAT_SECOND = 1;
  localparam int ST_BAT_FIRST  = 2;
  localparam int ST_LOW_MAIN   = 3;
  localparam int ST_ON_BACKUP  = 4;
  localparam int ST_M2B_VALID  = 5;
  localparam int ST_B2M_VALID  = 6;

  // control field positions
  localparam int CT_BROWNOUT_LSB  = 0;
  localparam int CT_TEMP_SENSE    = 4;
  localparam int CT_BACKUP_TEMP   = 5;
  localparam int CT_CLEAR_STAMPS  = 6;
  localparam int CT_FREQ_OUT_EN   = 7;
  localparam int CT_FREQ_OUT_BAT  = 8;

  // irq status bit positions
  localparam int IRQ_TO_BACKUP = 0;
  localparam int IRQ_TO_MAIN   = 1;
  localparam int IRQ_LOW_MAIN  = 2;
  localparam int IRQ_BAT_LOW   = 3;
  localparam int IRQ_WIDTH     = 4;

  localparam logic [2:0] BROWNOUT_LEVELS = 3'h6;
  localparam logic [2:0] BROWNOUT_RESET  = 3'h0;
  localparam int         STAMP_W         = 32;

  // battery measurement settles over a fixed number of cycles
  localparam int MEAS_TIME_US = 100;
  localparam int CLK_MHZ      = 50;
  localparam int MEAS_CYCLES  = MEAS_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic main_lt_bat_minus_hys;
    logic main_lt_trip;
    logic main_gt_bat_plus_hys;
    logic main_gt_trip_plus_hys;
  } bps_cmp_t;

  typedef enum logic [1:0] {
    BPS_MAIN,
    BPS_BACKUP
  } bps_mode_t;

endpackage
`default_nettype wire

// >>> src/bps_monitor.sv
// Summary of operation
// - Enter backup only when main below battery-minus-hysteresis and below trip.
// - Leave backup when main above battery-plus-hys or trip-plus-hys.
// - Serial host interface disabled while in backup mode.
// - Timekeeping keeps counting across switchover; block never stalls calendar.
// - Frequency output stays off in backup unless the freq-out-battery control bit enables it.
// - Stamp time on each switchover; keep first to-backup, latest to-main.
// - Stamps held until host writes clear-stamps as one.
// - Temperature compensation runs in backup only with backup-temp enable.
// - Total-power-fail flag set on power-up after losing both supplies.
// - Low-main flag set when main below one of six selected levels.
// - Brownout alone never disables the serial host interface.
// - Between 85% and 75% set first flag; below 75% set both.
// - No battery measurement in backup; flags updated only under main.
// - Writing temp-sense enable as one triggers a battery measurement.
`timescale 1ns/1ns
`default_nettype none
module bps_monitor
  import bps_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire bps_cmp_t             cmp,
  input  wire logic [5:0]           brownout_below,
  input  wire logic                 bat_below_85,
  input  wire logic                 bat_below_75,
  input  wire logic                 all_power_lost,
  input  wire logic [STAMP_W-1:0]   calendar_now,
  output logic                      on_backup,
  output logic                      host_if_enable,
  output logic                      temp_comp_enable,
  output logic                      freq_out_enable,
  output logic                      calendar_run,
  output logic                      irq
);

  bps_mode_t            mode;
  logic [STAMP_W-1:0]   m2b_stamp;
  logic [STAMP_W-1:0]   b2m_stamp;
  logic                 m2b_valid;
  logic                 b2m_valid;
  logic                 total_power_fail_flag;
  logic                 low_main_supply_flag;
  logic                 battery_low_first_flag;
  logic                 battery_low_second_flag;
  logic [2:0]           brownout_sel;
  logic                 temp_sense_enable;
  logic                 backup_temp_sense_enable;
  logic                 freq_en;
  logic                 freq_bat_en;
  logic [IRQ_WIDTH-1:0] irq_stat;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [12:0]          meas_cnt;
  logic                 meas_busy;
  logic                 strap_done;
  logic                 ack;

  // slave answers one cycle after the request is seen
  wire req        = avs_read | avs_write;
  wire wr_acc     = avs_write & ack;
  wire rd_acc     = avs_read & ack;
  wire wr_status  = wr_acc & (avs_address == ADDR_STATUS);
  wire wr_control = wr_acc & (avs_address == ADDR_CONTROL);
  wire wr_istat   = wr_acc & (avs_address == ADDR_IRQ_STAT);
  wire wr_imask   = wr_acc & (avs_address == ADDR_IRQ_MASK);
  wire in_backup  = (mode == BPS_BACKUP);

  wire go_backup = !in_backup && cmp.main_lt_bat_minus_hys
                   && cmp.main_lt_trip;
  wire go_main   = in_backup && (cmp.main_gt_bat_plus_hys
                   || cmp.main_gt_trip_plus_hys);

  wire clr_stamps = wr_control & avs_writedata[CT_CLEAR_STAMPS];
  wire meas_start = wr_control & avs_writedata[CT_TEMP_SENSE]
                    & !in_backup & !meas_busy;
  wire meas_end   = meas_busy && (meas_cnt == 13'(MEAS_CYCLES - 1));
  // padded so that the two disabled select codes never index past the end
  wire [7:0] below_ext = {2'h0, brownout_below};
  wire brown_hit  = brownout_sel < BROWNOUT_LEVELS
                    && below_ext[brownout_sel];

  wire [IRQ_WIDTH-1:0] irq_event;
  assign irq_event[IRQ_TO_BACKUP] = go_backup;
  assign irq_event[IRQ_TO_MAIN]   = go_main;
  assign irq_event[IRQ_LOW_MAIN]  = brown_hit & !low_main_supply_flag;
  assign irq_event[IRQ_BAT_LOW]   = meas_end & (bat_below_85 | bat_below_75);

  assign avs_waitrequest  = req & !ack;
  assign on_backup        = in_backup;
  assign host_if_enable   = !in_backup;
  assign calendar_run     = 1'b1;
  assign temp_comp_enable = in_backup ? backup_temp_sense_enable
                                      : temp_sense_enable;
  assign freq_out_enable  = freq_en & (!in_backup | freq_bat_en);
  assign irq              = |(irq_stat & irq_mask);

  wire [31:0] status_word = {25'h0, b2m_valid, m2b_valid, in_backup,
                             low_main_supply_flag, battery_low_first_flag,
                             battery_low_second_flag, total_power_fail_flag};
  wire [31:0] control_word = {23'h0, freq_bat_en, freq_en, 1'b0,
                              backup_temp_sense_enable, temp_sense_enable,
                              1'b0, brownout_sel};
  wire [31:0] rd_mux =
    (avs_address == ADDR_STATUS)   ? status_word :
    (avs_address == ADDR_CONTROL)  ? control_word :
    (avs_address == ADDR_M2B)      ? m2b_stamp :
    (avs_address == ADDR_B2M)      ? b2m_stamp :
    (avs_address == ADDR_IRQ_STAT) ? {28'h0, irq_stat} :
    (avs_address == ADDR_IRQ_MASK) ? {28'h0, irq_mask} : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= req & !ack;
      if (req & !ack) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode <= BPS_MAIN;
    end else if (go_backup) begin
      mode <= BPS_BACKUP;
    end else if (go_main) begin
      mode <= BPS_MAIN;
    end
  end

  // to-backup stamp keeps the first event; a clear in the same cycle lets the new event be stamped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      m2b_stamp <= '0;
      b2m_stamp <= '0;
      m2b_valid <= 1'b0;
      b2m_valid <= 1'b0;
    end else begin
      if (go_backup && (!m2b_valid || clr_stamps)) begin
        m2b_stamp <= calendar_now;
        m2b_valid <= 1'b1;
      end else if (clr_stamps) begin
        m2b_stamp <= '0;
        m2b_valid <= 1'b0;
      end
      if (go_main) begin
        b2m_stamp <= calendar_now;
        b2m_valid <= 1'b1;
      end else if (clr_stamps) begin
        b2m_stamp <= '0;
        b2m_valid <= 1'b0;
      end
    end
  end

  // power-loss strap sampled at the first edge after reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_done            <= 1'b0;
      total_power_fail_flag <= 1'b0;
    end else begin
      strap_done <= 1'b1;
      if (!strap_done && all_power_lost) begin
        total_power_fail_flag <= 1'b1;
      end else if (wr_status && avs_writedata[ST_TOTAL_FAIL]) begin
        total_power_fail_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_main_supply_flag <= 1'b0;
    end else if (brown_hit) begin
      low_main_supply_flag <= 1'b1;
    end else if (wr_status && avs_writedata[ST_LOW_MAIN]) begin
      low_main_supply_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meas_busy <= 1'b0;
      meas_cnt  <= '0;
    end else if (meas_start) begin
      meas_busy <= 1'b1;
      meas_cnt  <= '0;
    end else if (meas_end || in_backup) begin
      meas_busy <= 1'b0;
    end else if (meas_busy) begin
      meas_cnt <= meas_cnt + 13'd1;
    end
  end

  // flags only move at the end of a measurement made on main supply
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      battery_low_first_flag  <= 1'b0;
      battery_low_second_flag <= 1'b0;
    end else if (meas_end && !in_backup) begin
      battery_low_first_flag  <= bat_below_85 | bat_below_75;
      battery_low_second_flag <= bat_below_75;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      brownout_sel             <= BROWNOUT_RESET;
      temp_sense_enable        <= 1'b0;
      backup_temp_sense_enable <= 1'b0;
      freq_en                  <= 1'b0;
      freq_bat_en              <= 1'b0;
      irq_mask                 <= '0;
    end else begin
      if (wr_control) begin
        brownout_sel             <= avs_writedata[CT_BROWNOUT_LSB +: 3];
        temp_sense_enable        <= avs_writedata[CT_TEMP_SENSE];
        backup_temp_sense_enable <= avs_writedata[CT_BACKUP_TEMP];
        freq_en                  <= avs_writedata[CT_FREQ_OUT_EN];
        freq_bat_en              <= avs_writedata[CT_FREQ_OUT_BAT];
      end
      if (wr_imask) begin
        irq_mask <= avs_writedata[IRQ_WIDTH-1:0];
      end
    end
  end

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~({IRQ_WIDTH{wr_istat}}
                   & avs_writedata[IRQ_WIDTH-1:0])) | irq_event;
    end
  end

  chk_backup_entry: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (mode == BPS_MAIN && !(cmp.main_lt_bat_minus_hys && cmp.main_lt_trip))
    |=> mode == BPS_MAIN) else $error("backup entered early");
  chk_backup_both: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!in_backup && cmp.main_lt_bat_minus_hys && cmp.main_lt_trip)
    |=> in_backup) else $error("backup not entered");
  chk_main_return: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (in_backup && cmp.main_gt_trip_plus_hys) |=> mode == BPS_MAIN)
    else $error("no return to main");
  chk_main_bat_return: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (in_backup && cmp.main_gt_bat_plus_hys) |=> mode == BPS_MAIN)
    else $error("no return on battery margin");
  chk_host_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    in_backup |-> !host_if_enable) else $error("host active on backup");
  chk_host_brownout: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !in_backup |-> host_if_enable) else $error("host cut without backup");
  chk_freq_backup: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (in_backup && !freq_bat_en) |-> !freq_out_enable)
    else $error("freq out left on in backup");
  chk_stamp_first: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (go_backup && m2b_valid && !clr_stamps) |=> $stable(m2b_stamp))
    else $error("first stamp overwritten");
  chk_stamp_capture: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (go_backup && !m2b_valid)
    |=> m2b_valid && m2b_stamp == $past(calendar_now))
    else $error("backup stamp missing");
  chk_stamp_latest: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    go_main |=> b2m_stamp == $past(calendar_now))
    else $error("return stamp missing");
  chk_stamp_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clr_stamps && !go_main) |=> !b2m_valid)
    else $error("stamp not cleared");
  chk_m2b_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clr_stamps && !go_backup) |=> !m2b_valid)
    else $error("backup stamp not cleared");
  chk_temp_comp_sel: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (in_backup && !backup_temp_sense_enable) |-> !temp_comp_enable)
    else $error("compensation on in backup");
  chk_total_fail_set: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!strap_done && all_power_lost) |=> total_power_fail_flag)
    else $error("power fail flag not set");
  chk_total_fail_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (total_power_fail_flag && !(wr_status && avs_writedata[ST_TOTAL_FAIL]))
    |=> total_power_fail_flag) else $error("power fail flag lost");
  chk_brownout_flag: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    brown_hit |=> low_main_supply_flag && (host_if_enable || in_backup))
    else $error("brownout flag lost");
  chk_low_main_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (low_main_supply_flag && !(wr_status && avs_writedata[ST_LOW_MAIN]))
    |=> low_main_supply_flag) else $error("low main flag lost");
  chk_bat_levels: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    battery_low_second_flag |-> battery_low_first_flag)
    else $error("battery flags inconsistent");
  chk_bat_frozen: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(meas_end && !in_backup) |=> $stable(battery_low_first_flag)
      && $stable(battery_low_second_flag))
    else $error("battery flags moved without measurement");
  chk_meas_length: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (meas_start ##1 (!in_backup) [*8]) |-> meas_busy)
    else $error("measurement cut short");
  chk_meas_abort: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    in_backup |=> !meas_busy) else $error("measurement ran on backup");
  chk_bus_answer: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(req) |-> ##[0:1] !avs_waitrequest) else $error("bus hung");
  chk_read_data: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rd_acc |-> avs_readdata == $past(rd_mux))
    else $error("read data not standing");
  chk_irq_event_wins: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    go_backup |=> irq_stat[IRQ_TO_BACKUP]) else $error("event lost to clear");

  cov_to_backup: cover property (@(posedge clk_sys) disable iff (!rst_n)
    go_backup);
  cov_round_trip: cover property (@(posedge clk_sys) disable iff (!rst_n)
    go_backup ##[1:50] go_main);
  cov_meas_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
    meas_end && bat_below_75);
  cov_brownout: cover property (@(posedge clk_sys) disable iff (!rst_n)
    brown_hit && !low_main_supply_flag);
  cov_meas_abort: cover property (@(posedge clk_sys) disable iff (!rst_n)
    meas_busy && in_backup);

endmodule // bps_monitor
`default_nettype wire

// >>> tb/bps_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module bps_host_model
  import bps_pkg::*;
(
  input  wire logic        clk_sys,
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // released lines show junk so stale values are never trusted
    avs_address   <= ~a;
    avs_writedata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // battery flags mean nothing until a triggered measurement ends
  task automatic measure(output logic [31:0] st);
    wr(ADDR_CONTROL, 32'h0000_0010);
    repeat (MEAS_CYCLES + 4) @(posedge clk_sys);
    rd(ADDR_STATUS, st);
  endtask
endmodule // bps_host_model
`default_nettype wire

// >>> tb/backup_power_switch_monitor_test.sv
`timescale 1ns/1ns
`default_nettype none
module backup_power_switch_monitor_test
  import bps_pkg::*;
;
  typedef struct packed {
    bps_cmp_t    c;
    logic [31:0] t;
    logic        b;
  } bps_row_t;
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, calendar_now;
  bps_cmp_t    cmp;
  logic [5:0]  brownout_below;
  logic        bat_below_85, bat_below_75, all_power_lost, irq_a;
  logic        on_backup, host_if_enable, temp_comp_enable;
  logic        freq_out_enable, calendar_run, irq;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  bps_row_t    rows [7] = '{'{4'h8, 32'h0000_0001, 1'b0},
    '{4'h4, 32'h0000_0002, 1'b0}, '{4'hc, 32'h0000_0a01, 1'b1},
    '{4'h0, 32'h0000_0004, 1'b1}, '{4'h2, 32'h0000_0b02, 1'b0},
    '{4'hc, 32'h0000_0a03, 1'b1}, '{4'h1, 32'h0000_0b04, 1'b0}};
  bps_monitor uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmp(cmp), .brownout_below(brownout_below),
    .bat_below_85(bat_below_85), .bat_below_75(bat_below_75),
    .all_power_lost(all_power_lost), .calendar_now(calendar_now),
    .on_backup(on_backup), .host_if_enable(host_if_enable),
    .temp_comp_enable(temp_comp_enable),
    .freq_out_enable(freq_out_enable), .calendar_run(calendar_run),
    .irq(irq));
  bps_host_model host (.clk_sys(clk_sys), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // three cycles cover any input synchroniser in front of the mode logic
  task automatic go(input bps_cmp_t c, input logic [31:0] t);
    @(posedge clk_sys);
    cmp          <= c;
    calendar_now <= t;
    repeat (3) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    cmp = 4'h0;
    calendar_now = 32'h0000_0000;
    brownout_below = 6'h00;
    bat_below_85 = 1'b0;
    bat_below_75 = 1'b0;
    all_power_lost = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("rst_backup", on_backup, 1'b0);
    chk("rst_host_if", host_if_enable, 1'b1);
    chk("rst_cal", calendar_run, 1'b1);
    chk("rst_irq", irq, 1'b0);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    all_power_lost <= 1'b0;
    host.rd(ADDR_STATUS, q);
    chk("total_fail", q[ST_TOTAL_FAIL], 1'b1);
    host.wr(ADDR_STATUS, 32'h0000_0001);
    host.rd(ADDR_STATUS, q);
    chk("total_fail_clr", q[ST_TOTAL_FAIL], 1'b0);
    foreach (rows[i]) begin
      go(rows[i].c, rows[i].t);
      chk("on_backup", on_backup, rows[i].b);
      chk("host_if", host_if_enable, !rows[i].b);
      chk("cal_run", calendar_run, 1'b1);
    end
    host.rd(ADDR_M2B, q);
    chk("m2b", q, 32'h0000_0a01);
    host.rd(ADDR_B2M, q);
    chk("b2m", q, 32'h0000_0b04);
    host.rd(ADDR_STATUS, q);
    chk("stamp_valid", q[6:4], 3'h6);
    host.rd(ADDR_IRQ_STAT, q);
    chk("irq_stat", q[3:0], 4'h3);
    host.wr(ADDR_IRQ_MASK, 32'h0000_000f);
    repeat (2) @(posedge clk_sys);
    irq_a = irq;
    host.wr(ADDR_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    chk("irq_on", irq_a, 1'b1);
    chk("irq_off", irq, 1'b0);
    host.wr(ADDR_IRQ_STAT, 32'h0000_000f);
    repeat (2) @(posedge clk_sys);
    chk("irq_clr", irq, 1'b0);
    host.rd(ADDR_IRQ_STAT, q);
    chk("irq_stat_clr", q[3:0], 4'h0);
    host.wr(ADDR_CONTROL, 32'h0000_0040);
    host.rd(ADDR_M2B, q);
    chk("m2b_clr", q, 32'h0000_0000);
    host.rd(ADDR_STATUS, q);
    chk("valid_clr", q[6:5], 2'h0);
    go(4'hc, 32'h0000_0c05);
    go(4'h2, 32'h0000_0c06);
    host.rd(ADDR_M2B, q);
    chk("m2b_new", q, 32'h0000_0c05);
    for (int b = 0; b < 2; b++) begin
      host.wr(ADDR_CONTROL, 32'(32'h80 | (b << 5) | (b << 8)));
      go(4'hc, 32'h0000_0000);
      chk("temp_comp", temp_comp_enable, b[0]);
      chk("freq_out", freq_out_enable, b[0]);
      go(4'h1, 32'h0000_0000);
      chk("freq_main", freq_out_enable, 1'b1);
    end
    for (int k = 0; k < 6; k++) begin
      host.wr(ADDR_CONTROL, 32'(k));
      brownout_below <= ~(6'h01 << k);
      repeat (3) @(posedge clk_sys);
      host.rd(ADDR_STATUS, q);
      chk("low_main_off", q[ST_LOW_MAIN], 1'b0);
      brownout_below <= 6'h01 << k;
      repeat (3) @(posedge clk_sys);
      host.rd(ADDR_STATUS, q);
      chk("low_main_on", q[ST_LOW_MAIN], 1'b1);
      chk("host_if_bo", host_if_enable, 1'b1);
      brownout_below <= 6'h00;
      repeat (3) @(posedge clk_sys);
      host.rd(ADDR_STATUS, q);
      chk("low_main_hold", q[ST_LOW_MAIN], 1'b1);
      host.wr(ADDR_STATUS, 32'h0000_0008);
      host.rd(ADDR_STATUS, q);
      chk("low_main_clr", q[ST_LOW_MAIN], 1'b0);
    end
    bat_below_85 <= 1'b1;
    host.measure(q);
    chk("bat_first", q[2:1], 2'h2);
    bat_below_75 <= 1'b1;
    host.measure(q);
    chk("bat_both", q[2:1], 2'h3);
    bat_below_85 <= 1'b0;
    bat_below_75 <= 1'b0;
    host.rd(ADDR_STATUS, q);
    chk("bat_hold", q[2:1], 2'h3);
    host.wr(ADDR_CONTROL, 32'h0000_0010);
    go(4'hc, 32'h0000_0000);
    go(4'h1, 32'h0000_0000);
    repeat (MEAS_CYCLES) @(posedge clk_sys);
    host.rd(ADDR_STATUS, q);
    chk("bat_backup", q[2:1], 2'h3);
    chk("temp_comp_main", temp_comp_enable, 1'b1);
    host.rd(ADDR_IRQ_STAT, q);
    chk("irq_all", q[3:0], 4'hf);
    host.wr(8'h18, 32'hffff_ffff);
    host.rd(8'h18, q);
    chk("unmapped", q, 32'h0000_0000);
    host.rd(ADDR_CONTROL, q);
    chk("control_rb", q, 32'h0000_0010);
    conclude();
  end
endmodule // backup_power_switch_monitor_test
`default_nettype wire
